/* hw/ahs_homing_top.sv */
// Purpose: Homing sequencer for one motion axis, methods 27 to 35.
// Assumes: Switch and index inputs are synchronous to aclk; registers over AXI4-Lite.
// Notes: A start is taken only while idle; abort stops motion without a home latch.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
// Contract
// R1: 27, switch off: negative fast, reverse slow on switch on, latch on off.
// R2: 27, switch on: positive slow, latch when switch turns off.
// R3: 27, negative limit: reverse fast, slow on switch on, latch on off.
// R4: 28, switch off: negative fast, latch when switch turns on.
// R5: 28, switch on: positive slow, reverse slow on off, latch on on.
// R6: 28, after limit reverse: fast through switch, reverse on off, latch on.
// R7: 29, switch off: negative fast, slow on on, reverse on off, latch on.
// R8: 29, switch on: negative slow, reverse slow on off, latch on on.
// R9: 29, negative limit: reverse fast, latch when switch turns on.
// R10: 30: negative, fast then slow on switch on, latch on off.
// R11: 30, after limit reverse: reverse slow on switch on, latch on off.
// R12: Methods 31 and 32 are reserved with no homing behaviour.
// R13: 33: negative slow, latch at first index pulse.
// R14: 34: positive slow, latch at first index pulse.
// R15: 35: no motion, present position taken as home at once.
// R16: Stop and signal done on latch; refuse bad methods with error, no motion.
// R17: Inputs sampled synchronously; decisions use their edges, not levels. The start and limit decisions also read the switch level.
module ahs_homing_top #(
   parameter int POS_W = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic home_command,
   input wire logic home_switch,
   input wire logic neg_limit,
   input wire logic index_pulse,
   input wire logic [POS_W-1:0] axis_position,
   output logic move_enable,
   output logic move_negative,
   output logic speed_slow,
   output logic [POS_W-1:0] home_position,
   output logic homing_done,
   output logic homing_error
);
   logic [2:0] sw_level;
   logic [2:0] sw_rise;
   logic [2:0] sw_fall;
   logic hs;
   logic hs_on;
   logic hs_off;
   logic lim_on;
   logic idx_on;
   logic cmd_ff;
   logic cmd_edge;
   logic start_pulse;
   logic abort_pulse;
   logic start_any;
   logic [7:0] method_ff;
   ahs_pkg::ahs_state_t state_ff;
   logic busy;
   logic latch;
   logic refuse;
   logic set_move;
   logic nxt_neg;
   logic nxt_slow;
   ahs_pkg::ahs_state_t nxt_state;
   logic aw_ff;
   logic w_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic do_write;

   ahs_edge_sync #(.WIDTH(3)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({index_pulse, neg_limit, home_switch}),
      .level(sw_level),
      .rise(sw_rise),
      .fall(sw_fall)
   );

   // Edges steer the sequence, with the switch level also read at the start and at the limit, so a switch held on never re-fires. R17
   assign hs = sw_level[0];
   assign hs_on = sw_rise[0];
   assign hs_off = sw_fall[0];
   assign lim_on = sw_rise[1];
   assign idx_on = sw_rise[2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_ff <= 1'b0;
      end else begin
         cmd_ff <= home_command;
      end
   end

   assign cmd_edge = home_command & ~cmd_ff;
   assign busy = (state_ff != ahs_pkg::ST_IDLE);
   assign start_any = (cmd_edge | start_pulse) & ~busy;

   function automatic logic method_valid(input logic [7:0] m);
      return (m >= ahs_pkg::METHOD_27 && m <= ahs_pkg::METHOD_30) ||
         (m >= ahs_pkg::METHOD_33 && m <= ahs_pkg::METHOD_35);
   endfunction

   // Sequencer decision: next state, direction, speed and the latch moment.
   always_comb begin
      nxt_state = state_ff;
      nxt_neg = move_negative;
      nxt_slow = speed_slow;
      latch = 1'b0;
      refuse = 1'b0;
      set_move = move_enable;
      if (abort_pulse && busy) begin
         nxt_state = ahs_pkg::ST_IDLE;
         set_move = 1'b0;
      end else if (start_any) begin
         set_move = 1'b1;
         nxt_state = ahs_pkg::ST_SEEK;
         nxt_neg = 1'b1;
         nxt_slow = 1'b0;
         unique case (method_ff)
            ahs_pkg::METHOD_27: begin
               if (hs) begin
                  nxt_neg = 1'b0; // R2
                  nxt_slow = 1'b1;
                  nxt_state = ahs_pkg::ST_LEAVE;
               end
            end
            ahs_pkg::METHOD_28: begin
               if (hs) begin
                  nxt_neg = 1'b0; // R5
                  nxt_slow = 1'b1;
                  nxt_state = ahs_pkg::ST_LEAVE;
               end
            end
            ahs_pkg::METHOD_29, ahs_pkg::METHOD_30: begin
               if (hs) begin
                  nxt_slow = 1'b1; // R8 R10
                  nxt_state = ahs_pkg::ST_LEAVE;
               end
            end
            ahs_pkg::METHOD_33: begin
               nxt_slow = 1'b1; // R13
               nxt_state = ahs_pkg::ST_INDEX;
            end
            ahs_pkg::METHOD_34: begin
               nxt_neg = 1'b0; // R14
               nxt_slow = 1'b1;
               nxt_state = ahs_pkg::ST_INDEX;
            end
            ahs_pkg::METHOD_35: begin
               latch = 1'b1; // R15
               set_move = 1'b0;
               nxt_state = ahs_pkg::ST_IDLE;
            end
            default: begin
               // Reserved 31, 32 and anything outside 27..35. R12 R16
               refuse = 1'b1;
               set_move = 1'b0;
               nxt_state = ahs_pkg::ST_IDLE;
            end
         endcase
      end else begin
         unique case (state_ff)
            ahs_pkg::ST_IDLE: begin
               set_move = 1'b0;
            end
            ahs_pkg::ST_SEEK: begin
               // Moving negative, fast, switch off, toward the switch or the limit.
               if (lim_on && !hs) begin
                  nxt_neg = 1'b0; // R3 R6 R9 R11
                  nxt_state = ahs_pkg::ST_RETURN;
               end else if (hs_on) begin
                  unique case (method_ff)
                     ahs_pkg::METHOD_27: begin
                        nxt_neg = 1'b0; // R1
                        nxt_slow = 1'b1;
                        nxt_state = ahs_pkg::ST_LEAVE;
                     end
                     ahs_pkg::METHOD_28: begin
                        latch = 1'b1; // R4
                     end
                     default: begin
                        nxt_slow = 1'b1; // R7 R10
                        nxt_state = ahs_pkg::ST_LEAVE;
                     end
                  endcase
               end
            end
            ahs_pkg::ST_LEAVE: begin
               // Crossing the switch; its falling edge either latches or reverses.
               if (hs_off) begin
                  if (method_ff == ahs_pkg::METHOD_27 ||
                      method_ff == ahs_pkg::METHOD_30) begin
                     latch = 1'b1; // R1 R2 R3 R10 R11
                  end else begin
                     nxt_neg = ~move_negative; // R5 R6 R7 R8
                     nxt_slow = (method_ff != ahs_pkg::METHOD_28) || speed_slow;
                     nxt_state = ahs_pkg::ST_INDEX;
                  end
               end
            end
            ahs_pkg::ST_RETURN: begin
               // Travelling positive after the limit; waits for the switch.
               if (hs_on) begin
                  unique case (method_ff)
                     ahs_pkg::METHOD_27: begin
                        nxt_slow = 1'b1; // R3
                        nxt_state = ahs_pkg::ST_LEAVE;
                     end
                     ahs_pkg::METHOD_28: begin
                        nxt_state = ahs_pkg::ST_LEAVE; // R6
                     end
                     ahs_pkg::METHOD_29: begin
                        latch = 1'b1; // R9
                     end
                     default: begin
                        nxt_neg = 1'b1; // R11
                        nxt_slow = 1'b1;
                        nxt_state = ahs_pkg::ST_LEAVE;
                     end
                  endcase
               end
            end
            ahs_pkg::ST_INDEX: begin
               // Methods 33/34 wait for the index; 28/29 wait for switch on again.
               if (method_ff == ahs_pkg::METHOD_33 || method_ff == ahs_pkg::METHOD_34) begin
                  latch = idx_on; // R13 R14
               end else begin
                  latch = hs_on; // R5 R6 R7 R8
               end
            end
            default: begin
               nxt_state = ahs_pkg::ST_IDLE;
               set_move = 1'b0;
            end
         endcase
         if (latch) begin
            nxt_state = ahs_pkg::ST_IDLE;
            set_move = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ahs_pkg::ST_IDLE;
         move_enable <= 1'b0;
         move_negative <= 1'b0;
         speed_slow <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         move_enable <= set_move; // R16
         move_negative <= nxt_neg;
         speed_slow <= nxt_slow;
      end
   end

   // Done and error are levels held until the next start.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         home_position <= '0;
         homing_done <= 1'b0;
         homing_error <= 1'b0;
      end else if (latch) begin
         home_position <= axis_position;
         homing_done <= 1'b1; // R16
         homing_error <= 1'b0;
      end else if (refuse) begin
         homing_done <= 1'b0;
         homing_error <= 1'b1; // R16
      end else if (start_any) begin
         homing_done <= 1'b0;
         homing_error <= 1'b0;
      end
   end

   // AXI4-Lite write path: address and data captured independently.
   assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
   assign s_axi_wready = ~w_ff & ~s_axi_bvalid;
   assign do_write = aw_ff & w_ff & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ahs_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_ff == ahs_pkg::OFF_CTRL ||
               awaddr_ff == ahs_pkg::OFF_METHOD) ? ahs_pkg::RESP_OKAY : ahs_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Method changes are ignored while busy so a run never switches mode midway.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         method_ff <= ahs_pkg::METHOD_RESET;
      end else if (do_write && awaddr_ff == ahs_pkg::OFF_METHOD && wstrb_ff[0] && !busy) begin
         method_ff <= wdata_ff[7:0];
      end
   end

   assign start_pulse = do_write && awaddr_ff == ahs_pkg::OFF_CTRL && wstrb_ff[0] &&
      wdata_ff[ahs_pkg::CTRL_START_BIT];
   assign abort_pulse = do_write && awaddr_ff == ahs_pkg::OFF_CTRL && wstrb_ff[0] &&
      wdata_ff[ahs_pkg::CTRL_ABORT_BIT];

   // AXI4-Lite read path: one read at a time, answered the cycle after the address.
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ahs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= ahs_pkg::RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         unique case (s_axi_araddr)
            ahs_pkg::OFF_CTRL: s_axi_rdata <= 32'h0000_0000;
            ahs_pkg::OFF_METHOD: s_axi_rdata <= {24'h00_0000, method_ff};
            ahs_pkg::OFF_STATUS: begin
               s_axi_rdata[ahs_pkg::ST_BUSY_BIT] <= busy;
               s_axi_rdata[ahs_pkg::ST_DONE_BIT] <= homing_done;
               s_axi_rdata[ahs_pkg::ST_ERR_BIT] <= homing_error;
               s_axi_rdata[ahs_pkg::ST_MOVE_BIT] <= move_enable;
               s_axi_rdata[ahs_pkg::ST_DIR_BIT] <= move_negative;
               s_axi_rdata[ahs_pkg::ST_SLOW_BIT] <= speed_slow;
               s_axi_rdata[ahs_pkg::ST_HOME_SW_BIT] <= hs;
               s_axi_rdata[ahs_pkg::ST_NLIM_BIT] <= sw_level[1];
            end
            ahs_pkg::OFF_HOME_POS: s_axi_rdata <= 32'(home_position);
            ahs_pkg::OFF_AXIS_POS: s_axi_rdata <= 32'(axis_position);
            default: s_axi_rresp <= ahs_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Only bits 7:0 of the method register exist; upper bits and strobes 3:1 ignored.
endmodule
`default_nettype wire

/* hw/ahs_pkg.sv */
// Purpose: Shared constants for the axis homing sequencer.
// Assumes: One motion axis, AXI4-Lite register access, 32-bit data.
// Notes: Offsets are byte addresses of aligned 32-bit registers.
`default_nettype none
package ahs_pkg;
   localparam logic [7:0] METHOD_27 = 8'h1B;
   localparam logic [7:0] METHOD_28 = 8'h1C;
   localparam logic [7:0] METHOD_29 = 8'h1D;
   localparam logic [7:0] METHOD_30 = 8'h1E;
   localparam logic [7:0] METHOD_31 = 8'h1F;
   localparam logic [7:0] METHOD_32 = 8'h20;
   localparam logic [7:0] METHOD_33 = 8'h21;
   localparam logic [7:0] METHOD_34 = 8'h22;
   localparam logic [7:0] METHOD_35 = 8'h23;

   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_METHOD = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_HOME_POS = 8'h0C;
   localparam logic [7:0] OFF_AXIS_POS = 8'h10;

   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_ABORT_BIT = 1;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_ERR_BIT = 2;
   localparam int ST_MOVE_BIT = 3;
   localparam int ST_DIR_BIT = 4;
   localparam int ST_SLOW_BIT = 5;
   localparam int ST_HOME_SW_BIT = 6;
   localparam int ST_NLIM_BIT = 7;

   localparam logic [7:0] METHOD_RESET = 8'h1B;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SEEK,
      ST_LEAVE,
      ST_RETURN,
      ST_INDEX
   } ahs_state_t;
endpackage
`default_nettype wire

/* hw/ahs_edge_sync.sv */
// Purpose: Samples the axis inputs and flags their rising and falling edges.
// Assumes: Inputs are synchronous to aclk.
// Notes: Edges are flagged in the same cycle as the registered level changes.
`default_nettype none
module ahs_edge_sync #(
   parameter int WIDTH = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] cur_ff;
   logic [WIDTH-1:0] prev_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur_ff <= '0;
         prev_ff <= '0;
      end else begin
         cur_ff <= din;
         prev_ff <= cur_ff;
      end
   end

   assign level = cur_ff;
   assign rise = cur_ff & ~prev_ff;
   assign fall = ~cur_ff & prev_ff;
endmodule
`default_nettype wire

/* dv/ahs_axis_model.sv */
// Purpose: Behavioural servo axis with home switch, negative limit and index mark.
// Assumes: One count per cycle at slow speed, FAST counts per cycle at fast speed.
// Notes: Switches are decoded from position, so they never bounce.
`default_nettype none
module ahs_axis_model #(
   parameter int FAST = 4,
   parameter int SW_LO = 100,
   parameter int SW_HI = 139,
   parameter int IDX = 64
) (
   input wire logic aclk,
   input wire logic set_en,
   input wire logic [31:0] set_pos,
   input wire logic move_enable,
   input wire logic move_negative,
   input wire logic speed_slow,
   output logic [31:0] axis_position,
   output logic home_switch,
   output logic neg_limit,
   output logic index_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos;
   int step;
   assign step = speed_slow ? 1 : FAST;
   always_ff @(posedge aclk) begin
      if (set_en) begin
         pos <= set_pos;
      end else if (move_enable) begin
         pos <= move_negative ? pos - step : pos + step;
      end
   end
   assign axis_position = 32'(pos);
   assign home_switch = pos >= SW_LO && pos <= SW_HI;
   assign neg_limit = pos <= 0;
   // The mark repeats every IDX counts, so the first one met depends on direction.
   assign index_pulse = pos % IDX == 0;
endmodule
`default_nettype wire

/* dv/ahs_chk.sv */
// Purpose: Port-level assertions for the homing sequencer.
// Assumes: One clock domain, reset active low.
// Notes: Switch, limit and index edge decisions take two edges to reach the outputs; a home command edge takes one.
`default_nettype none
module ahs_chk #(
   parameter int POS_W = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_wvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic home_command,
   input wire logic home_switch,
   input wire logic neg_limit,
   input wire logic index_pulse,
   input wire logic move_enable,
   input wire logic move_negative,
   input wire logic speed_slow,
   input wire logic [POS_W-1:0] home_position,
   input wire logic homing_done,
   input wire logic homing_error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_err_still;
      homing_error |-> !move_enable;
   endproperty
   a_err_still: assert property (p_err_still)
      else $error("motion while error flagged");
   property p_done_still;
      homing_done |-> !move_enable;
   endproperty
   a_done_still: assert property (p_done_still)
      else $error("motion while done flagged");
   property p_latch_hold;
      // A method 35 start may re-latch while done is already up.
      homing_done && $past(homing_done) && !$past(home_command) && !s_axi_bvalid
         |-> $stable(home_position);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("home position moved after latch");
   property p_cmd_answer;
      $rose(home_command) && !move_enable |-> ##[1:4] (move_enable || homing_done || homing_error);
   endproperty
   a_cmd_answer: assert property (p_cmd_answer)
      else $error("home command got no answer");
   // Abort arrives over the bus, so quiet windows also exclude write traffic.
   sequence s_quiet;
      (!$changed(home_switch) && !$changed(neg_limit) && !$changed(index_pulse)
       && !$changed(home_command) && !s_axi_wvalid) [*4];
   endsequence
   property p_quiet_hold;
      s_quiet |-> $stable(move_enable) && $stable(move_negative) && $stable(speed_slow);
   endproperty
   a_quiet_hold: assert property (p_quiet_hold)
      else $error("motion changed without an input edge");
   property p_limit_turn;
      $rose(neg_limit) && move_enable && move_negative && !speed_slow && !home_switch
         |-> ##[1:4] (!move_negative || !move_enable);
   endproperty
   a_limit_turn: assert property (p_limit_turn)
      else $error("no reversal at negative limit");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer)
      else $error("read not answered next cycle");
   c_done: cover property ($rose(homing_done));
   c_err: cover property ($rose(homing_error));
   c_limit: cover property ($rose(neg_limit) && move_enable);
endmodule
bind ahs_homing_top ahs_chk #(.POS_W(POS_W)) i_chk (.*);
`default_nettype wire

/* dv/axis_homing_sequencer_tb.sv */
// Purpose: Self-checking bench for the axis homing sequencer.
// Assumes: Home switch spans 100 to 139, limit at 0, index every 64 counts.
// Notes: Motion is recorded as 2-bit segments {negative, slow} behind a marker bit.
`default_nettype none
module axis_homing_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, home_command = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, last;
   logic [31:0] s_axi_rdata, axis_position, home_position;
   logic home_switch, neg_limit, index_pulse, move_enable, move_negative, speed_slow;
   logic homing_done, homing_error, last_en;
   logic set_en = 1'b1, rec_clr = 1'b1;
   logic [31:0] set_pos = 32'h12C;
   logic [15:0] sig;
   int errors = 0;
   int tests_run = 0;
   ahs_homing_top i_dut (.*);
   ahs_axis_model i_axis (.*);
   initial begin
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (rec_clr) begin
         sig <= 16'h0001;
      end else if (move_enable === 1'b1 && (!last_en || last != {move_negative, speed_slow})) begin
         sig <= {sig[13:0], move_negative, speed_slow};
      end
      last_en <= move_enable;
      last <= {move_negative, speed_slow};
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
      end
      // Bready stays high between writes, so no signal is driven twice in one step.
      chk("bvalid", 32'h1, 32'(s_axi_bvalid));
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
      end
      chk("rvalid", 32'h1, 32'(s_axi_rvalid));
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask
   // A latch lands a few counts past the switch edge, so position is judged in a window.
   task automatic run_home(input logic [7:0] m, input int p, input logic [15:0] es,
                           input int eh, input logic via_reg);
      int tol;
      int diff;
      tol = (m == 8'h23) ? 0 : 16;
      axi_wr(ahs_pkg::OFF_METHOD, {24'h0, m}, ahs_pkg::RESP_OKAY);
      set_pos <= p;
      set_en <= 1'b1;
      rec_clr <= 1'b1;
      @(posedge aclk);
      set_en <= 1'b0;
      repeat (8) @(posedge aclk);
      rec_clr <= 1'b0;
      if (via_reg) axi_wr(ahs_pkg::OFF_CTRL, 32'h1, ahs_pkg::RESP_OKAY);
      else home_command <= 1'b1;
      repeat (3) @(posedge aclk);
      for (int n = 0; n < 3000 && homing_done !== 1'b1 && homing_error !== 1'b1; n++)
         @(posedge aclk);
      home_command <= 1'b0;
      chk("motion", 32'(es), 32'(sig));
      if (es == 16'h0001 && m != 8'h23) begin
         chk("error", 32'h1, {30'h0, homing_done, homing_error});
      end else begin
         chk("done_stop", 32'h2, {30'h0, homing_done, move_enable});
         diff = int'(home_position) - eh;
         tests_run++;
         if (diff > tol || diff < -tol) begin
            errors++;
            $display("[ERR] home_position expected %0d seen %0d", eh, home_position);
         end
      end
   endtask
   task automatic tally_and_finish();
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      $display("[ERR] watchdog expected finish seen hang");
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      set_en <= 1'b0;
      chk("outs_rst", 32'h0, {29'h0, move_enable, homing_done, homing_error});
      rd_chk(ahs_pkg::OFF_METHOD, {24'h0, ahs_pkg::METHOD_RESET}, ahs_pkg::RESP_OKAY);
      rd_chk(ahs_pkg::OFF_CTRL, 32'h0, ahs_pkg::RESP_OKAY);
      rd_chk(ahs_pkg::OFF_AXIS_POS, 32'h12C, ahs_pkg::RESP_OKAY);
      rd_chk(8'h20, 32'h0, ahs_pkg::RESP_SLVERR);
      axi_wr(ahs_pkg::OFF_STATUS, 32'hFF, ahs_pkg::RESP_SLVERR);
      run_home(8'h1B, 300, 16'h0019, 140, 1'b0);
      run_home(8'h1B, 120, 16'h0005, 140, 1'b0);
      run_home(8'h1B, 60, 16'h0061, 140, 1'b0);
      run_home(8'h1C, 300, 16'h0006, 139, 1'b0);
      run_home(8'h1C, 120, 16'h0017, 139, 1'b0);
      run_home(8'h1C, 60, 16'h0062, 139, 1'b0);
      run_home(8'h1D, 300, 16'h006D, 100, 1'b0);
      run_home(8'h1D, 120, 16'h001D, 100, 1'b0);
      run_home(8'h1D, 60, 16'h0018, 100, 1'b0);
      run_home(8'h1E, 300, 16'h001B, 99, 1'b0);
      run_home(8'h1E, 120, 16'h0007, 99, 1'b0);
      run_home(8'h1E, 60, 16'h0063, 99, 1'b0);
      run_home(8'h1F, 300, 16'h0001, 0, 1'b0);
      run_home(8'h20, 300, 16'h0001, 0, 1'b0);
      run_home(8'h1A, 300, 16'h0001, 0, 1'b0);
      run_home(8'h24, 300, 16'h0001, 0, 1'b1);
      run_home(8'h21, 300, 16'h0007, 256, 1'b1);
      run_home(8'h22, 300, 16'h0005, 320, 1'b0);
      run_home(8'h23, 300, 16'h0001, 300, 1'b0);
      // A start loads the negative direction unless method 34, or 27 or 28 on the switch, overrides it; method 35 loads it too.
      rd_chk(ahs_pkg::OFF_STATUS, 32'h12, ahs_pkg::RESP_OKAY);
      axi_wr(ahs_pkg::OFF_METHOD, 32'h22, ahs_pkg::RESP_OKAY);
      home_command <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("moving", 32'h1, 32'(move_enable));
      axi_wr(ahs_pkg::OFF_METHOD, 32'h21, ahs_pkg::RESP_OKAY);
      axi_wr(ahs_pkg::OFF_CTRL, 32'h2, ahs_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("aborted", 32'h0, {30'h0, move_enable, homing_done});
      rd_chk(ahs_pkg::OFF_METHOD, 32'h22, ahs_pkg::RESP_OKAY);
      home_command <= 1'b0;
      tally_and_finish();
   end
endmodule
`default_nettype wire
